// ---- logic/vtss_in_sync.sv ----
// Three-stage input synchroniser with agreement-based edge detection.
`timescale 1ns/10ps
`default_nettype none
module vtss_in_sync
   import vtss_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Asynchronous input and result
   input wire logic async_in,
   output logic rise
);
   logic [2:0] sync_q;
   logic level_q;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         sync_q <= 3'h0;
      end else begin
         sync_q <= {sync_q[1:0], async_in};
      end
   end

   // The level only moves once stages two and three agree, so the first stage feeds nothing else.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         level_q <= 1'h0;
      end else if (sync_q[1] == sync_q[2]) begin
         level_q <= sync_q[2];
      end
   end

   assign rise = (sync_q[1] == sync_q[2]) && sync_q[2] && !level_q;
endmodule
`default_nettype wire

// ---- logic/vtss_pkg.sv ----
// Package of constants and types for the vision trigger source selector.
package vtss_pkg;

   // ****************************************************************
   // Timing of the internal trigger generator
   // ****************************************************************
   localparam int unsigned VTSS_CLK_MHZ = 100;
   localparam int unsigned VTSS_INT_PERIOD_MS = 50;
   localparam int unsigned VTSS_INT_TOL_MS = 5;
   localparam int unsigned VTSS_INT_PERIOD_CYC = VTSS_INT_PERIOD_MS * 1000 * VTSS_CLK_MHZ;
   localparam int unsigned VTSS_INT_CNT_W = 23;

   // ****************************************************************
   // Configuration ranges and reset values
   // ****************************************************************
   localparam logic [2:0] VTSS_RACK_MAX = 3'h7;
   localparam logic [2:0] VTSS_RACK_RST = 3'h7;
   localparam logic VTSS_RIO_EN_RST = 1'h1;
   localparam logic VTSS_CAM_RST = 1'h0;
   localparam logic VTSS_ACTIVE_RST = 1'h0;
   localparam int unsigned VTSS_SYNC_STAGES = 3;

   // ****************************************************************
   // Trigger source codes
   // ****************************************************************
   typedef enum logic [2:0] {
      VTSS_SRC_NONE = 3'h0,
      VTSS_SRC_INT1 = 3'h1,
      VTSS_SRC_IO1 = 3'h2,
      VTSS_SRC_HOST1 = 3'h3,
      VTSS_SRC_INT2 = 3'h4,
      VTSS_SRC_IO2 = 3'h5,
      VTSS_SRC_HOST2 = 3'h6
   } vtss_src_e;

   localparam logic [2:0] VTSS_SRC_RST = 3'h0;

   typedef enum logic {
      VTSS_SETUP_INT = 1'h0,
      VTSS_SETUP_RUN = 1'h1
   } vtss_setup_e;

endpackage

// ---- logic/vtss_top.sv ----
// Trigger source selection for two inspection tool sets.
`timescale 1ns/10ps
`default_nettype none
module vtss_top
   import vtss_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Mode: high in run mode, low during configuration
   input wire logic run_mode,
   // Settings write strobe and values
   input wire logic cfg_wr,
   input wire logic [2:0] cfg_src1,
   input wire logic [2:0] cfg_src2,
   input wire logic cfg_setup1,
   input wire logic cfg_setup2,
   input wire logic cfg_cam1,
   input wire logic cfg_cam2,
   input wire logic cfg_active,
   input wire logic cfg_rio_en,
   input wire logic [3:0] cfg_rack,
   output logic cfg_reject,
   // Front-panel trigger pins
   input wire logic panel_trig1,
   input wire logic panel_trig2,
   // Host trigger pulses per path, same clock domain
   input wire logic bp_trig1,
   input wire logic bp_trig2,
   input wire logic rio_trig1,
   input wire logic rio_trig2,
   input wire logic ser_trig1,
   input wire logic ser_trig2,
   // Applied settings
   output logic [2:0] src1_q,
   output logic [2:0] src2_q,
   output logic setup1_q,
   output logic setup2_q,
   output logic cam1_q,
   output logic cam2_q,
   output logic active_q,
   output logic rio_en_q,
   output logic [2:0] rack_q,
   output logic rio_active,
   // Acquisition requests
   output logic acq1_q,
   output logic acq1_cam_q,
   output logic acq2_q,
   output logic acq2_cam_q,
   output logic view_cam_q
);
   import vtss_pkg::*;

   // ****************************************************************
   // Settings
   // ****************************************************************
   logic src_ok;
   logic rack_ok;
   logic cam1_chg;
   logic cam2_chg;

   assign rack_ok = (cfg_rack <= {1'h0, VTSS_RACK_MAX});
   // Set 1 must use a source 1 code; set 2 may use source 1 only when set 1 does.
   always_comb begin
      src_ok = 1'h0;
      if (cfg_src1 <= 3'(VTSS_SRC_HOST1)) begin
         if (cfg_src2 == 3'(VTSS_SRC_NONE) || cfg_src2 == cfg_src1) begin
            src_ok = 1'h1;
         end else if (cfg_src2 >= 3'(VTSS_SRC_INT2) && cfg_src2 <= 3'(VTSS_SRC_HOST2)) begin
            src_ok = 1'h1;
         end
      end
   end

   assign cfg_reject = cfg_wr && !(rack_ok && src_ok);

   // A rejected write leaves every setting as it was, so settings stay mutually legal.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         src1_q <= VTSS_SRC_RST;
         src2_q <= VTSS_SRC_RST;
         setup1_q <= 1'h0;
         setup2_q <= 1'h0;
         cam1_q <= VTSS_CAM_RST;
         cam2_q <= VTSS_CAM_RST;
         active_q <= VTSS_ACTIVE_RST;
         rio_en_q <= VTSS_RIO_EN_RST;
         rack_q <= VTSS_RACK_RST;
      end else if (cfg_wr && rack_ok && src_ok) begin
         src1_q <= cfg_src1;
         src2_q <= cfg_src2;
         setup1_q <= cfg_setup1;
         setup2_q <= cfg_setup2;
         cam1_q <= cfg_cam1;
         cam2_q <= cfg_cam2;
         active_q <= cfg_active;
         rio_en_q <= cfg_rio_en;
         rack_q <= cfg_rack[2:0];
      end
   end

   assign cam1_chg = cfg_wr && rack_ok && src_ok && (cfg_cam1 != cam1_q);
   assign cam2_chg = cfg_wr && rack_ok && src_ok && (cfg_cam2 != cam2_q);
   assign rio_active = rio_en_q;

   // ****************************************************************
   // Internal periodic generator
   // ****************************************************************
   // Exactly 50 ms, inside the allowed 5 ms tolerance.
   logic [VTSS_INT_CNT_W-1:0] int_cnt_q;
   logic int_tick;

   assign int_tick = (int_cnt_q == VTSS_INT_CNT_W'(VTSS_INT_PERIOD_CYC - 1));

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         int_cnt_q <= '0;
      end else if (int_tick) begin
         int_cnt_q <= '0;
      end else begin
         int_cnt_q <= int_cnt_q + VTSS_INT_CNT_W'(1);
      end
   end

   // ****************************************************************
   // Trigger inputs
   // ****************************************************************
   logic pan1;
   logic pan2;
   logic host1;
   logic host2;

   vtss_in_sync u_sync1 (
      .core_clk(core_clk),
      .nrst(nrst),
      .async_in(panel_trig1),
      .rise(pan1)
   );

   vtss_in_sync u_sync2 (
      .core_clk(core_clk),
      .nrst(nrst),
      .async_in(panel_trig2),
      .rise(pan2)
   );

   // Remote port triggers only count while the port is enabled.
   assign host1 = bp_trig1 || (rio_en_q && rio_trig1) || ser_trig1;
   assign host2 = bp_trig2 || (rio_en_q && rio_trig2) || ser_trig2;

   function automatic logic pick(input logic [2:0] src, input logic t_int, input logic p1,
                                 input logic p2, input logic h1, input logic h2);
      logic r;
      r = 1'h0;
      case (src)
         3'(VTSS_SRC_INT1), 3'(VTSS_SRC_INT2): r = t_int;
         3'(VTSS_SRC_IO1): r = p1;
         3'(VTSS_SRC_IO2): r = p2;
         3'(VTSS_SRC_HOST1): r = h1;
         3'(VTSS_SRC_HOST2): r = h2;
         default: r = 1'h0;
      endcase
      return r;
   endfunction

   // ****************************************************************
   // Trigger selection and acquisition
   // ****************************************************************
   logic run1;
   logic run2;
   logic trig1;
   logic trig2;

   assign run1 = pick(src1_q, int_tick, pan1, pan2, host1, host2);
   assign run2 = pick(src2_q, int_tick, pan1, pan2, host1, host2);

   // Run sources apply in run mode; setup choice applies only in configuration.
   always_comb begin
      if (run_mode) begin
         trig1 = run1;
         trig2 = run2;
      end else begin
         trig1 = (setup1_q == VTSS_SETUP_RUN) ? run1 : int_tick;
         trig2 = (setup2_q == VTSS_SETUP_RUN) ? run2 : int_tick;
      end
   end

   // One cycle request per accepted trigger; camera change also forces a fresh image.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         acq1_q <= 1'h0;
         acq1_cam_q <= VTSS_CAM_RST;
         acq2_q <= 1'h0;
         acq2_cam_q <= VTSS_CAM_RST;
      end else begin
         acq1_q <= trig1 || cam1_chg;
         acq1_cam_q <= cam1_chg ? cfg_cam1 : cam1_q;
         acq2_q <= trig2 || cam2_chg;
         acq2_cam_q <= cam2_chg ? cfg_cam2 : cam2_q;
      end
   end

   // Camera shown during configuration follows the active tool set.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         view_cam_q <= VTSS_CAM_RST;
      end else begin
         view_cam_q <= active_q ? cam2_q : cam1_q;
      end
   end
endmodule
`default_nettype wire

// ---- test/test_vtss_top.sv ----
// Self-checking testbench of the trigger source selector.
`timescale 1ns/10ps
`default_nettype none
module test_vtss_top;
   import vtss_pkg::*;
   logic core_clk = 1'b0, nrst = 1'b0, run_mode = 1'b0, cfg_wr = 1'b0;
   logic [2:0] cfg_src1 = 3'h0, cfg_src2 = 3'h0;
   logic cfg_setup1 = 1'b0, cfg_setup2 = 1'b0, cfg_cam1 = 1'b0, cfg_cam2 = 1'b0;
   logic cfg_active = 1'b0, cfg_rio_en = 1'b1;
   logic [3:0] cfg_rack = 4'h7;
   wire logic panel_trig1, panel_trig2, bp_trig1, bp_trig2, rio_trig1, rio_trig2;
   wire logic ser_trig1, ser_trig2;
   logic cfg_reject, setup1_q, setup2_q, cam1_q, cam2_q, active_q, rio_en_q, rio_active;
   logic acq1_q, acq1_cam_q, acq2_q, acq2_cam_q, view_cam_q;
   logic [2:0] src1_q, src2_q, rack_q;
   int fail_count = 0, num_checks = 0, n1 = 0, n2 = 0, b1 = 0, b2 = 0;
   vtss_top DUT (.core_clk, .nrst, .run_mode, .cfg_wr, .cfg_src1, .cfg_src2, .cfg_setup1,
      .cfg_setup2, .cfg_cam1, .cfg_cam2, .cfg_active, .cfg_rio_en, .cfg_rack, .cfg_reject,
      .panel_trig1, .panel_trig2, .bp_trig1, .bp_trig2, .rio_trig1, .rio_trig2, .ser_trig1,
      .ser_trig2, .src1_q, .src2_q, .setup1_q, .setup2_q, .cam1_q, .cam2_q, .active_q,
      .rio_en_q, .rack_q, .rio_active, .acq1_q, .acq1_cam_q, .acq2_q, .acq2_cam_q, .view_cam_q);
   vtss_far far (.core_clk, .panel_trig1, .panel_trig2, .bp_trig1, .bp_trig2, .rio_trig1,
      .rio_trig2, .ser_trig1, .ser_trig2);
   initial begin
      forever #5 core_clk = ~core_clk;
   end
   // Counting on the falling edge keeps clear of the launch edge.
   always @(negedge core_clk) begin
      if (acq1_q === 1'b1) n1++;
      if (acq2_q === 1'b1) n2++;
   end
   task chk(input logic [11:0] seen, input logic [11:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task set(input logic [2:0] s1, s2, input logic st, c1, act, en, input logic [3:0] rk,
      input logic rej);
      {cfg_src1, cfg_src2, cfg_setup1, cfg_setup2} = {s1, s2, st, st};
      {cfg_cam1, cfg_cam2, cfg_active, cfg_rio_en, cfg_rack} = {c1, ~c1, act, en, rk};
      cfg_wr = 1'b1;
      #1 chk(cfg_reject, rej);
      cyc(1);
      cfg_wr = 1'b0;
      b1 = n1;
      b2 = n2;
   endtask
   task acq(input logic [7:0] e1, e2);
      cyc(8);
      chk(8'(n1 - b1), e1);
      chk(8'(n2 - b2), e2);
   endtask
   task t_reset;
      chk({src1_q, src2_q, acq1_q, acq2_q}, 8'h00);
      chk({rack_q, rio_en_q, rio_active, setup1_q, setup2_q, cam1_q, cam2_q, active_q},
         10'h3E0);
      $display("reset values done");
   endtask
   task t_cfg;
      set(3'h0, 3'h0, 0, 0, 0, 1, 4'h8, 1);
      chk(rack_q, 3'h7);
      set(3'h0, 3'h0, 0, 0, 0, 1, 4'h0, 0);
      chk(rack_q, 3'h0);
      set(3'h4, 3'h0, 0, 0, 0, 1, 4'h7, 1);
      set(3'h3, 3'h0, 0, 0, 0, 1, 4'h7, 0);
      set(3'h3, 3'h3, 0, 0, 0, 1, 4'h7, 0);
      set(3'h3, 3'h1, 0, 0, 0, 1, 4'h7, 1);
      set(3'h3, 3'h7, 0, 0, 0, 1, 4'h7, 1);
      set(3'h3, 3'h6, 0, 0, 0, 1, 4'h7, 0);
      chk({src1_q, src2_q, rack_q}, 9'h0F7);
      $display("settings checks done");
   endtask
   task t_host;
      run_mode = 1'b1;
      set(3'h3, 3'h3, 0, 0, 0, 1, 4'h7, 0);
      for (int p = 0; p < 3; p++) begin
         far.pulse(2 + 2 * p, 1);
         acq(p + 1, p + 1);
      end
      set(3'h3, 3'h3, 0, 0, 0, 0, 4'h7, 0);
      chk(rio_active, 1'b0);
      far.pulse(4, 1);
      acq(0, 0);
      set(3'h0, 3'h0, 0, 0, 0, 1, 4'h7, 0);
      far.pulse(2, 1);
      far.pulse(0, 5);
      acq(0, 0);
      $display("host and none done");
   endtask
   task t_panel;
      set(3'h2, 3'h5, 0, 0, 0, 1, 4'h7, 0);
      far.pulse(0, 5);
      acq(1, 0);
      far.pulse(1, 5);
      acq(1, 1);
      set(3'h2, 3'h2, 0, 0, 0, 1, 4'h7, 0);
      far.pulse(0, 5);
      acq(1, 1);
      $display("panel done");
   endtask
   task t_setup;
      run_mode = 1'b0;
      set(3'h3, 3'h0, 1, 1, 1, 1, 4'h7, 0);
      acq(1, 1);
      chk({cam1_q, cam2_q, view_cam_q}, 3'h4);
      set(3'h3, 3'h0, 1, 1, 0, 1, 4'h7, 0);
      cyc(1);
      chk(view_cam_q, 1'b1);
      far.pulse(2, 1);
      acq(1, 0);
      set(3'h3, 3'h0, 0, 1, 0, 1, 4'h7, 0);
      far.pulse(2, 1);
      acq(0, 0);
      $display("setup done");
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      #200000;
      fail_count++;
      complete_run();
   end
   initial begin
      cyc(12);
      nrst = 1'b1;
      t_reset();
      t_cfg();
      t_host();
      t_panel();
      t_setup();
      complete_run();
   end
endmodule
`default_nettype wire

// ---- test/vtss_chk.sv ----
// Port-level assertions for the trigger source selector.
`timescale 1ns/10ps
`default_nettype none
module vtss_chk
   import vtss_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Watched inputs
   input wire logic run_mode,
   input wire logic cfg_wr,
   input wire logic cfg_cam1,
   input wire logic [3:0] cfg_rack,
   input wire logic bp_trig1,
   // Watched outputs
   input wire logic cfg_reject,
   input wire logic [2:0] src1_q,
   input wire logic setup1_q,
   input wire logic cam1_q,
   input wire logic cam2_q,
   input wire logic active_q,
   input wire logic rio_en_q,
   input wire logic [2:0] rack_q,
   input wire logic rio_active,
   input wire logic acq1_q,
   input wire logic acq1_cam_q,
   input wire logic view_cam_q
);
   import vtss_pkg::*;
   logic view_d;
   assign view_d = active_q ? cam2_q : cam1_q;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   rack_range_a: assert property (cfg_wr && cfg_rack > 4'h7 |-> cfg_reject)
      else $error("rack above seven not refused");
   reject_hold_a: assert property (cfg_wr && cfg_reject |=> $stable(rack_q) && $stable(src1_q))
      else $error("refused write changed settings");
   rack_load_a: assert property (cfg_wr && !cfg_reject |=> {1'h0, rack_q} == $past(cfg_rack))
      else $error("accepted rack not loaded");
   rio_state_a: assert property (rio_active == rio_en_q)
      else $error("remote port activity differs from enable");
   cam_toggle_a: assert property (cfg_wr && !cfg_reject && cfg_cam1 != cam1_q
      |=> acq1_q && acq1_cam_q == cam1_q)
      else $error("camera toggle gave no acquisition");
   none_quiet_a: assert property (run_mode && src1_q == VTSS_SRC_NONE && !cfg_wr |=> !acq1_q)
      else $error("acquisition with source none");
   host_acq_a: assert property (run_mode && src1_q == VTSS_SRC_HOST1 && bp_trig1 && !cfg_wr
      |=> acq1_q && acq1_cam_q == cam1_q)
      else $error("host trigger not acted on");
   set1_code_a: assert property (src1_q <= 3'h3)
      else $error("tool set one holds a set two source");
   setup_follow_a: assert property (!run_mode && setup1_q && src1_q == VTSS_SRC_HOST1 && bp_trig1
      |=> acq1_q)
      else $error("setup follow ignored run trigger");
   view_sel_a: assert property (!cfg_wr |=> view_cam_q == $past(view_d))
      else $error("shown camera not of active set");
   cover property (cfg_wr && cfg_reject);
   cover property (run_mode && acq1_q);
   cover property (!run_mode && acq1_q);
endmodule
bind vtss_top vtss_chk u_chk (.core_clk, .nrst, .run_mode, .cfg_wr, .cfg_cam1, .cfg_rack,
   .bp_trig1, .cfg_reject, .src1_q, .setup1_q, .cam1_q, .cam2_q, .active_q, .rio_en_q,
   .rack_q, .rio_active, .acq1_q, .acq1_cam_q, .view_cam_q);
`default_nettype wire

// ---- test/vtss_far.sv ----
// Model of the production equipment and host that drive the trigger lines.
`timescale 1ns/10ps
`default_nettype none
module vtss_far (
   // Clock
   input wire logic core_clk,
   // Trigger lines
   output logic panel_trig1,
   output logic panel_trig2,
   output logic bp_trig1,
   output logic bp_trig2,
   output logic rio_trig1,
   output logic rio_trig2,
   output logic ser_trig1,
   output logic ser_trig2
);
   logic [7:0] line_q = 8'h00;
   assign {ser_trig2, ser_trig1, rio_trig2, rio_trig1} = line_q[7:4];
   assign {bp_trig2, bp_trig1, panel_trig2, panel_trig1} = line_q[3:0];
   // Panel pins are held for several cycles since the block syncs them.
   // Host paths get one-cycle pulses in the block's clock.
   task pulse(input int idx, input int len);
      @(posedge core_clk);
      #1 line_q[idx] = 1'b1;
      repeat (len) @(posedge core_clk);
      #1 line_q[idx] = 1'b0;
   endtask
endmodule
`default_nettype wire
